// ---- logic/llreg_cal_pkg.sv ----
// constants of the low-leakage regulator calibration block
// assumes a single 25 MHz system clock and an APB register port
package llreg_cal_pkg;
    // ***************************************************
    // register indexes, byte address is four times index
    // ***************************************************
    localparam logic [9:0]  IDX_CALIB_CONTROL = 10'h12F;
    localparam logic [9:0]  IDX_TRIM_LOW      = 10'h130;
    localparam logic [9:0]  IDX_TRIM_HIGH     = 10'h131;
    localparam int          ADDR_W            = 12;
    // ***************************************************
    // field positions of the control register, trim field widths
    // ***************************************************
    localparam int          BIT_ENABLE        = 0;
    localparam int          BIT_SHORT         = 1;
    localparam int          BIT_TCO           = 2;
    localparam int          BIT_ACTIVE        = 3;
    localparam int          BIT_COMP          = 4;
    localparam int          BIT_DONE          = 5;
    localparam int          HIGH_W            = 5;
    localparam int          LOW_W             = 4;
    // ***************************************************
    // reset values and trim limits
    // ***************************************************
    localparam logic        RST_ENABLE        = 1'b1;
    localparam logic        RST_TCO           = 1'b0;
    localparam logic        RST_SHORT         = 1'b0;
    localparam logic [4:0]  RST_TRIM_HIGH     = 5'h00;
    localparam logic [3:0]  RST_TRIM_LOW      = 4'h0;
    localparam logic [4:0]  HIGH_MAX          = 5'h10;
    localparam logic [3:0]  LOW_MAX           = 4'h8;
    // ***************************************************
    // timing: calibration clock period in system cycles
    // ***************************************************
    localparam int          CLK_PERIOD_NS     = 40;
    localparam int          CAL_PERIOD_NS     = 15625;
    localparam int          CAL_TICK_CYCLES   = CAL_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ---- logic/cal_tick_gen.sv ----
// divider giving the 64 kHz calibration enable pulse
// assumes clk_sys at the rate given in the package
`timescale 1ns/100ps
module cal_tick_gen
    import llreg_cal_pkg::*;
#(
    parameter int DIV = CAL_TICK_CYCLES
)(
    input  wire logic clk_sys,
    input  wire logic resetn,
    output logic      tick
);
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic        wrap;

    assign wrap      = (count_ff == 16'(DIV - 1));
    assign nxt_count = wrap ? 16'h0000 : count_ff + 16'h0001;
    assign tick      = wrap;

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            count_ff <= 16'h0000;
        else
            count_ff <= nxt_count;
    end
endmodule // cal_tick_gen

// ---- logic/cal_engine.sv ----
// calibration state machine, steps once per calibration tick
// assumes comparator high means regulator output still too high
`timescale 1ns/100ps
module cal_engine
    import llreg_cal_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire logic              tick,
    input  wire logic              enable,
    input  wire logic              compIn,
    output logic [HIGH_W-1:0]      trialHigh,
    output logic [LOW_W-1:0]       trialLow,
    output logic                   trialTco,
    output logic                   trialShort,
    output logic                   active,
    output logic                   doneLevel
);
    import llreg_cal_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_HIGH, ST_LOW, ST_TCO, ST_DONE} calState_t;

    calState_t          state_ff;
    logic [2:0]         bitIdx_ff;
    logic [HIGH_W-1:0]  hi_ff;
    logic [LOW_W-1:0]   lo_ff;
    logic               tco_ff;
    logic               short_ff;
    logic [HIGH_W-1:0]  hiKeep;
    logic [HIGH_W-1:0]  hiTry;
    logic [LOW_W-1:0]   loKeep;
    logic [LOW_W-1:0]   loTry;
    logic [2:0]         idxDown;

    // ***************************************************
    // successive approximation, clamped to trim limits
    // ***************************************************
    assign idxDown = bitIdx_ff - 3'd1;
    assign hiKeep  = compIn ? hi_ff : hi_ff & ~(HIGH_W'(1) << bitIdx_ff);
    assign hiTry   = hiKeep | (HIGH_W'(1) << idxDown);
    assign loKeep  = compIn ? lo_ff : lo_ff & ~(LOW_W'(1) << bitIdx_ff);
    assign loTry   = loKeep | (LOW_W'(1) << idxDown);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff  <= ST_IDLE;
            bitIdx_ff <= 3'd0;
            hi_ff     <= RST_TRIM_HIGH;
            lo_ff     <= RST_TRIM_LOW;
            tco_ff    <= RST_TCO;
            short_ff  <= RST_SHORT;
        end
        else if (!enable)
            state_ff <= ST_IDLE;
        else if (tick)
        begin
            case (state_ff)
                ST_IDLE, ST_DONE:
                begin
                    state_ff  <= ST_HIGH;
                    hi_ff     <= HIGH_MAX;
                    bitIdx_ff <= 3'(HIGH_W - 1);
                end
                ST_HIGH:
                begin
                    if (bitIdx_ff == 3'd0)
                    begin
                        hi_ff     <= hiKeep;
                        lo_ff     <= LOW_MAX;
                        bitIdx_ff <= 3'(LOW_W - 1);
                        state_ff  <= ST_LOW;
                    end
                    else
                    begin
                        hi_ff     <= (hiTry > HIGH_MAX) ? hiKeep : hiTry;
                        bitIdx_ff <= idxDown;
                    end
                end
                ST_LOW:
                begin
                    if (bitIdx_ff == 3'd0)
                    begin
                        lo_ff    <= loKeep;
                        state_ff <= ST_TCO;
                    end
                    else
                    begin
                        lo_ff     <= (loTry > LOW_MAX) ? loKeep : loTry;
                        bitIdx_ff <= idxDown;
                    end
                end
                ST_TCO:
                begin
                    tco_ff   <= compIn;
                    short_ff <= (lo_ff == 4'h0);
                    state_ff <= ST_DONE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    assign trialHigh  = hi_ff;
    assign trialLow   = lo_ff;
    assign trialTco   = tco_ff;
    assign trialShort = short_ff;
    assign active     = (state_ff != ST_IDLE);
    assign doneLevel  = (state_ff == ST_DONE);

    // ***************************************************
    // checks
    // ***************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_pass_restart:  assert property (doneLevel && enable && tick |=> state_ff == ST_HIGH)
        else $error("no new pass after done");
    a_halt_idle:     assert property (!enable |=> !active)
        else $error("calibration still active while disabled");
    a_high_range:    assert property (hi_ff <= HIGH_MAX)
        else $error("high trim beyond limit");
    a_low_range:     assert property (lo_ff <= LOW_MAX)
        else $error("low trim beyond limit");
    a_step_on_tick:  assert property (!tick && enable && $past(enable) |=> $stable(state_ff))
        else $error("state moved without calibration tick");
endmodule // cal_engine

// ---- logic/low_leak_reg_calibration.sv ----
// low-leakage regulator calibration control with APB registers
// assumes a zero-wait APB master and an analog regulator with comparator
`timescale 1ns/100ps
module low_leak_reg_calibration
    import llreg_cal_pkg::*;
#(
    parameter int TICK_DIV = CAL_TICK_CYCLES
)(
    input  wire logic                           clk_sys,
    input  wire logic                           resetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [llreg_cal_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic [31:0]                         prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           comparatorIn,
    output logic [llreg_cal_pkg::HIGH_W-1:0]    trimHighOut,
    output logic [llreg_cal_pkg::LOW_W-1:0]     trimLowOut,
    output logic                                tempCoeffOut,
    output logic                                shortSwitchOut,
    output logic                                calPowerOn
);
    import llreg_cal_pkg::*;

    logic               enable_ff;
    logic               tco_ff;
    logic               short_ff;
    logic [HIGH_W-1:0]  trimHigh_ff;
    logic [LOW_W-1:0]   trimLow_ff;
    logic               compStat_ff;
    logic               doneStat_ff;
    logic               activeStat_ff;
    logic               donePrev_ff;
    logic [31:0]        rdata_ff;
    logic [HIGH_W-1:0]  highOut_ff;
    logic [LOW_W-1:0]   lowOut_ff;
    logic               tcoOut_ff;
    logic               shortOut_ff;
    logic               power_ff;

    logic               tick;
    logic [HIGH_W-1:0]  trialHigh;
    logic [LOW_W-1:0]   trialLow;
    logic               trialTco;
    logic               trialShort;
    logic               active;
    logic               doneLevel;

    // ***************************************************
    // calibration tick and engine
    // ***************************************************
    cal_tick_gen #(.DIV(TICK_DIV)) u_tick (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick    (tick)
    );

    cal_engine u_engine (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .tick       (tick),
        .enable     (enable_ff),
        .compIn     (comparatorIn),
        .trialHigh  (trialHigh),
        .trialLow   (trialLow),
        .trialTco   (trialTco),
        .trialShort (trialShort),
        .active     (active),
        .doneLevel  (doneLevel)
    );

    // ***************************************************
    // bus decode
    // ***************************************************
    logic               setup;
    logic               access;
    logic               wrAccess;
    logic               hitCtrl;
    logic               hitLow;
    logic               hitHigh;
    logic               mapped;
    logic               swWritable;
    logic               loadResults;
    logic [7:0]         ctrlRead;
    logic [31:0]        nxt_rdata;

    assign setup       = psel && !penable;
    assign access      = psel && penable;
    assign hitCtrl     = (paddr == ADDR_W'({IDX_CALIB_CONTROL, 2'b00}));
    assign hitLow      = (paddr == ADDR_W'({IDX_TRIM_LOW, 2'b00}));
    assign hitHigh     = (paddr == ADDR_W'({IDX_TRIM_HIGH, 2'b00}));
    assign mapped      = hitCtrl || hitLow || hitHigh;
    assign wrAccess    = access && pwrite && mapped;
    assign swWritable  = !enable_ff;
    assign loadResults = doneLevel && !donePrev_ff;
    assign pready      = 1'b1;
    assign pslverr     = access && !mapped;

    // reserved bits 7:6 always read zero
    assign ctrlRead = {2'b00, doneStat_ff, compStat_ff, activeStat_ff,
                       tco_ff, short_ff, enable_ff};
    assign nxt_rdata = hitCtrl ? {24'h000000, ctrlRead} :
                       hitLow  ? {28'h0000000, trimLow_ff} :
                       hitHigh ? {27'h0, trimHigh_ff} : 32'h00000000;
    assign prdata = rdata_ff;

    // ***************************************************
    // registers
    // ***************************************************
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            enable_ff <= RST_ENABLE;
        else if (wrAccess && hitCtrl)
            enable_ff <= pwdata[BIT_ENABLE];
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            tco_ff      <= RST_TCO;
            short_ff    <= RST_SHORT;
            trimHigh_ff <= RST_TRIM_HIGH;
            trimLow_ff  <= RST_TRIM_LOW;
        end
        else if (loadResults && enable_ff)
        begin
            tco_ff      <= trialTco;
            short_ff    <= trialShort;
            trimHigh_ff <= trialHigh;
            trimLow_ff  <= trialLow;
        end
        else if (wrAccess && swWritable)
        begin
            if (hitCtrl)
            begin
                tco_ff   <= pwdata[BIT_TCO];
                short_ff <= pwdata[BIT_SHORT];
            end
            if (hitHigh)
                trimHigh_ff <= pwdata[HIGH_W-1:0];
            if (hitLow)
                trimLow_ff <= pwdata[LOW_W-1:0];
        end
    end

    // status bits registered into the bus view
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            compStat_ff   <= 1'b0;
            doneStat_ff   <= 1'b0;
            activeStat_ff <= 1'b0;
            donePrev_ff   <= 1'b0;
            rdata_ff      <= 32'h00000000;
        end
        else
        begin
            if (tick)
                compStat_ff <= comparatorIn;
            doneStat_ff   <= doneLevel;
            activeStat_ff <= active;
            donePrev_ff   <= doneLevel;
            if (setup && !pwrite)
                rdata_ff <= nxt_rdata;
        end
    end

    // ***************************************************
    // analog side drive
    // ***************************************************
    logic [HIGH_W-1:0]  nxt_highOut;
    logic [LOW_W-1:0]   nxt_lowOut;
    logic               nxt_tcoOut;
    logic               nxt_shortOut;

    // values pass straight except low trim, zeroed while shorted: larger code lowers the output
    assign nxt_highOut  = enable_ff ? trialHigh : trimHigh_ff;
    assign nxt_shortOut = enable_ff ? trialShort : short_ff;
    assign nxt_tcoOut   = enable_ff ? trialTco : tco_ff;
    assign nxt_lowOut   = nxt_shortOut ? 4'h0 :
                          (enable_ff ? trialLow : trimLow_ff);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            highOut_ff  <= RST_TRIM_HIGH;
            lowOut_ff   <= RST_TRIM_LOW;
            tcoOut_ff   <= RST_TCO;
            shortOut_ff <= RST_SHORT;
            power_ff    <= 1'b0;
        end
        else
        begin
            highOut_ff  <= nxt_highOut;
            lowOut_ff   <= nxt_lowOut;
            tcoOut_ff   <= nxt_tcoOut;
            shortOut_ff <= nxt_shortOut;
            power_ff    <= active;
        end
    end

    assign trimHighOut    = highOut_ff;
    assign trimLowOut     = lowOut_ff;
    assign tempCoeffOut   = tcoOut_ff;
    assign shortSwitchOut = shortOut_ff;
    assign calPowerOn     = power_ff;

    // ***************************************************
    // checks
    // ***************************************************
    int unsigned doneCnt;
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            doneCnt <= 0;
        else if (doneStat_ff)
            doneCnt <= doneCnt + 1;
        else
            doneCnt <= 0;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_done_width:    assert property ($fell(doneStat_ff) && $past(enable_ff) |->
                                      $past(doneCnt) == TICK_DIV - 1)
        else $error("done flag not one calibration period long");
    a_done_load:     assert property (loadResults && enable_ff |=>
                                      trimHigh_ff == $past(trialHigh)
                                      && trimLow_ff == $past(trialLow))
        else $error("results not loaded on done");
    a_comp_rate:     assert property ($changed(compStat_ff) |-> $past(tick))
        else $error("comparator status changed between ticks");
    a_power_active:  assert property (activeStat_ff == calPowerOn)
        else $error("analog power differs from active status");
    a_enabled_lock:  assert property (enable_ff && !loadResults |=>
                                      $stable(trimHigh_ff) && $stable(tco_ff)
                                      && $stable(trimLow_ff) && $stable(short_ff))
        else $error("software changed trims while enabled");
    a_short_masks:   assert property (shortSwitchOut |-> trimLowOut == 4'h0)
        else $error("low trim reaches regulator while shorted");
    a_held_drive:    assert property (!enable_ff ##1 !enable_ff |->
                                      trimHighOut == $past(trimHigh_ff))
        else $error("regulator not following held trim");
    a_resv_zero:     assert property (access && !pwrite && hitCtrl |-> prdata[7:6] == 2'b00)
        else $error("reserved control bits read non-zero");
    a_reset_enable:  assert property ($rose(resetn) |-> enable_ff)
        else $error("calibration not enabled after reset");

    // ***************************************************
    // checks on drive, loads and read back
    // ***************************************************
    a_drive_trial:   assert property (enable_ff ##1 enable_ff |->
                                      trimHighOut == $past(trialHigh))
        else $error("regulator not following calibration trial");

    a_load_flags:    assert property (loadResults && enable_ff |=>
                                      tco_ff == $past(trialTco) && short_ff == $past(trialShort))
        else $error("temperature and short bits not loaded on done");

    a_sw_bits:       assert property (wrAccess && hitCtrl && !enable_ff |=>
                                      tco_ff == $past(pwdata[BIT_TCO])
                                      && short_ff == $past(pwdata[BIT_SHORT]))
        else $error("control bit write lost while disabled");

    a_high_readback: assert property (access && !pwrite && hitHigh |->
                                      prdata == {27'h0, $past(trimHigh_ff)})
        else $error("high trim read differs from register");

    a_low_readback:  assert property (access && !pwrite && hitLow |->
                                      prdata == {28'h0, $past(trimLow_ff)})
        else $error("low trim read differs from register");

    a_comp_sample:   assert property (tick |=> compStat_ff == $past(comparatorIn))
        else $error("comparator status not taken on tick");

    a_unmapped_zero: assert property (access && !pwrite && !mapped |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule // low_leak_reg_calibration

// ---- dv/regulator_model.sv ----
// analog regulator and comparator model facing the calibration block
// assumes trim drive and power enable come from the calibration block
`timescale 1ns/100ps
module regulator_model #(
    parameter int TARGET = 140
)(
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    input  wire logic [4:0] trimHigh,
    input  wire logic [3:0] trimLow,
    input  wire logic       tco,
    input  wire logic       shortSw,
    input  wire logic       powerOn,
    output logic            compOut
);
    int level;
    // ******************************
    // output level and comparator
    // ******************************
    always_comb
    begin
        level = 200 - 6 * int'(trimHigh) + (tco ? 2 : 0);
        if (!shortSw)
            level = level - 3 * int'(trimLow);
    end
    // unpowered comparator gives no steady answer
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            compOut <= 1'b0;
        else if (powerOn)
            compOut <= (level > TARGET);
        else
            compOut <= ~compOut;
    end
endmodule // regulator_model

// ---- dv/low_leak_reg_calibration_tb.sv ----
// testbench of the regulator calibration block with a reference model
// assumes the regulator model beside it and an APB master in the bench
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checksDone++; if ((gt) !== (ex)) begin numErrors++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module low_leak_reg_calibration_tb;
    import llreg_cal_pkg::*;
    localparam logic [11:0] A_CTL = {IDX_CALIB_CONTROL, 2'b00};
    localparam logic [11:0] A_LOW = {IDX_TRIM_LOW, 2'b00};
    localparam logic [11:0] A_HIGH = {IDX_TRIM_HIGH, 2'b00};
    logic        clk_sys, resetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        comparatorIn, tempCoeffOut, shortSwitchOut, calPowerOn, err;
    logic [4:0]  trimHighOut;
    logic [3:0]  trimLowOut;
    int          numErrors, checksDone, mH, mL, mT, mS, rises, actSeen, seedVal;
    logic        prevDone;
    // ******************************
    // design, partner and clock
    // ******************************
    low_leak_reg_calibration #(.TICK_DIV(4)) dut (.clk_sys(clk_sys), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .comparatorIn(comparatorIn),
        .trimHighOut(trimHighOut), .trimLowOut(trimLowOut), .tempCoeffOut(tempCoeffOut),
        .shortSwitchOut(shortSwitchOut), .calPowerOn(calPowerOn));
    regulator_model partner (.clk_sys(clk_sys), .resetn(resetn), .trimHigh(trimHighOut),
        .trimLow(trimLowOut), .tco(tempCoeffOut), .shortSw(shortSwitchOut),
        .powerOn(calPowerOn), .compOut(comparatorIn));
    always #20 clk_sys = ~clk_sys;
    // ******************************
    // bus tasks and closing
    // ******************************
    task automatic apbXfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wrCtl(input int t, input int s, input int e);
        apbXfer(A_CTL, 1'b1, {24'h0, 2'($urandom), 3'h0, 1'(t), 1'(s), 1'(e)});
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, numErrors);
        if (numErrors == 0 && checksDone > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #(40 * 20000);
        numErrors++;
        conclude();
    end
    // ******************************
    // main sequence
    // ******************************
    initial
    begin
        clk_sys = 0; resetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
        numErrors = 0; checksDone = 0; rises = 0; actSeen = 0; prevDone = 0;
        seedVal = $urandom(64);
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        apbXfer(A_CTL, 1'b0, 32'h0);
        `CHK("ctl reset", 32'h01, rd & 32'hFFFF_FFC1)
        apbXfer(A_HIGH, 1'b0, 32'h0);
        `CHK("high reset", 32'h00, rd)
        `CHK("mapped no err", 1'b0, err)
        apbXfer(12'h000, 1'b0, 32'h0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        for (int i = 0; i < 200; i++)
        begin
            apbXfer(A_CTL, 1'b0, 32'h0);
            if (rd[BIT_DONE] === 1'b1 && !prevDone) rises++;
            if (rd[BIT_ACTIVE] === 1'b1 && calPowerOn === 1'b1) actSeen++;
            prevDone = rd[BIT_DONE];
        end
        `CHK("passes repeat", 1'b1, rises >= 2)
        `CHK("power while active", 1'b1, actSeen > 0)
        apbXfer(A_HIGH, 1'b0, 32'h0);
        `CHK("high range", 1'b1, rd <= 32'h10)
        apbXfer(A_LOW, 1'b0, 32'h0);
        `CHK("low range", 1'b1, rd <= 32'h08)
        wrCtl(0, 0, 0);
        for (int i = 0; i < 6; i++)
        begin
            mH = $urandom % 17; mL = $urandom % 9; mT = $urandom % 2; mS = $urandom % 2;
            apbXfer(A_HIGH, 1'b1, 32'($urandom) & 32'hFFFF_FFE0 | mH);
            apbXfer(A_LOW, 1'b1, 32'($urandom) & 32'hFFFF_FFF0 | mL);
            wrCtl(mT, mS, 0);
            repeat (3) @(posedge clk_sys);
            #1;
            `CHK("out high", 5'(mH), trimHighOut)
            `CHK("out low", 4'(mS ? 0 : mL), trimLowOut)
            `CHK("out tco", 1'(mT), tempCoeffOut)
            `CHK("out short", 1'(mS), shortSwitchOut)
            `CHK("power off", 1'b0, calPowerOn)
            apbXfer(A_CTL, 1'b0, 32'h0);
            `CHK("ctl read", 32'(mT * 4 + mS * 2), rd & 32'hFFFF_FFEF)
            apbXfer(A_HIGH, 1'b0, 32'h0);
            `CHK("high read", 32'(mH), rd)
            apbXfer(A_LOW, 1'b0, 32'h0);
            `CHK("low read", 32'(mL), rd)
        end
        wrCtl(mT, mS, 1);
        apbXfer(A_LOW, 1'b1, 32'((mL + 1) % 9));
        apbXfer(A_HIGH, 1'b1, 32'((mH + 1) % 17));
        wrCtl(1 - mT, 1 - mS, 1);
        wrCtl(mT, mS, 0);
        apbXfer(A_LOW, 1'b0, 32'h0);
        `CHK("low dropped", 32'(mL), rd)
        apbXfer(A_HIGH, 1'b0, 32'h0);
        `CHK("high dropped", 32'(mH), rd)
        apbXfer(A_CTL, 1'b0, 32'h0);
        `CHK("bits dropped", 32'(mT * 4 + mS * 2), rd & 32'h0000_0007)
        conclude();
    end
endmodule // low_leak_reg_calibration_tb
